//--- verilog/flm_ctrl.sv
`timescale 1ns/1ps
module flm_ctrl
  import flm_pkg::*;
#(
  parameter int P_ERASE_CYCLES = ERASE_CYCLES,
  parameter int P_PROG_CYCLES = PROG_CYCLES
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Special function register port
  input wire flm_bus_req_t i_bus,
  output logic [7:0] o_rdata,
  // Flash array
  output flm_flash_req_t o_flash,
  input wire logic [WORD_W-1:0] i_flash_rdata,
  // Processor pipeline
  output logic o_cycle_en,
  output logic o_fetch_discard,
  output logic o_cpu_halt,
  // Protection
  input wire logic [3:0] i_seg_protected,
  input wire logic i_powerup_timer_run
);

  // Registers
  logic [7:0] addr_low;
  logic [ADDR_HIGH_W-1:0] addr_high;
  logic [7:0] data_low;
  logic [DATA_HIGH_W-1:0] data_high;
  logic rd_bit;
  logic wr_bit;
  logic permit;

  // Sequencing state
  logic [2:0] div_cnt;
  logic [1:0] rd_cnt;
  logic [1:0] setup_cnt;
  logic [1:0] word_idx;
  logic flash_rd;
  logic capture;
  flm_state_t state;
  flm_state_t next_state;
  logic [WORD_W-1:0] wbuf [BLOCK_WORDS];

  // Address decode
  wire hit_ctl = i_bus.addr == ADDR_CONTROL;
  wire hit_unlock = i_bus.addr == ADDR_UNLOCK;
  wire hit_alow = i_bus.addr == ADDR_ADDR_LOW;
  wire hit_ahigh = i_bus.addr == ADDR_ADDR_HIGH;
  wire hit_dlow = i_bus.addr == ADDR_DATA_LOW;
  wire hit_dhigh = i_bus.addr == ADDR_DATA_HIGH;
  wire wr_ctl = i_bus.wr & hit_ctl;
  wire wr_unlock = i_bus.wr & hit_unlock;

  // Word address and block position
  wire [ADDR_W-1:0] word_addr = {addr_high, addr_low};
  wire [1:0] block_pos = addr_low[1:0];
  wire last_word = block_pos == BLOCK_LAST;
  wire seg_locked = i_seg_protected[word_addr[ADDR_W-1:ADDR_W-2]];
  wire idle = state == ST_IDLE;

  // Instruction cycle divider
  assign o_cycle_en = div_cnt == CYCLE_DIV - 3'h1;

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      div_cnt <= 3'h0;
    end else begin
      div_cnt <= o_cycle_en ? 3'h0 : div_cnt + 3'h1;
    end
  end

  // Unlock pair watcher
  logic unlock_armed;

  flm_unlock u_unlock (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_key_write(wr_unlock),
    .i_clear(i_bus.wr & ~hit_unlock),
    .i_wdata(i_bus.wdata),
    .o_armed(unlock_armed)
  );

  // Start requests; a zero written to a start bit does nothing
  wire set_rd = wr_ctl & i_bus.wdata[CTL_RD] & ~rd_bit & ~wr_bit & idle;
  wire wr_allowed = permit & i_bus.wdata[CTL_PERMIT];
  wire set_wr = wr_ctl & i_bus.wdata[CTL_WR] & ~wr_bit & ~rd_bit & idle
    & wr_allowed & unlock_armed & ~i_powerup_timer_run;

  // Read timing measured in instruction cycles
  wire rd_launch = rd_bit & o_cycle_en & rd_cnt == READ_DELAY - 2'h1;
  wire rd_finish = rd_bit & o_cycle_en & rd_cnt == READ_DELAY;
  assign o_fetch_discard = rd_bit & rd_cnt == READ_DELAY;

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      rd_cnt <= 2'h0;
    end else if (set_rd) begin
      rd_cnt <= 2'h0;
    end else if (rd_bit & o_cycle_en) begin
      rd_cnt <= rd_cnt + 2'h1;
    end
  end

  // Flash strobe, then capture one clock later
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      flash_rd <= 1'b0;
      capture <= 1'b0;
    end else begin
      flash_rd <= rd_launch;
      capture <= flash_rd;
    end
  end

  // Control register; start bits clear only by hardware
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      rd_bit <= 1'b0;
      wr_bit <= 1'b0;
      permit <= 1'b0;
    end else begin
      if (wr_ctl) begin
        permit <= i_bus.wdata[CTL_PERMIT];
      end
      if (set_rd) begin
        rd_bit <= 1'b1;
      end else if (rd_finish) begin
        rd_bit <= 1'b0;
      end
      if (set_wr) begin
        wr_bit <= 1'b1;
      end else if (state == ST_DONE) begin
        wr_bit <= 1'b0;
      end
    end
  end

  // Address registers
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      addr_low <= RESET_BYTE;
      addr_high <= '0;
    end else begin
      if (i_bus.wr & hit_alow) begin
        addr_low <= i_bus.wdata;
      end
      if (i_bus.wr & hit_ahigh) begin
        addr_high <= i_bus.wdata[ADDR_HIGH_W-1:0];
      end
    end
  end

  // Data registers; a completed read overrides a same-clock write
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      data_low <= RESET_BYTE;
      data_high <= '0;
    end else if (capture) begin
      data_low <= i_flash_rdata[7:0];
      data_high <= i_flash_rdata[WORD_W-1:8];
    end else begin
      if (i_bus.wr & hit_dlow) begin
        data_low <= i_bus.wdata;
      end
      if (i_bus.wr & hit_dhigh) begin
        data_high <= i_bus.wdata[DATA_HIGH_W-1:0];
      end
    end
  end

  // Word buffer; every started word is latched, including the last
  always_ff @(posedge i_clk_sys) begin
    if (set_wr) begin
      wbuf[block_pos] <= {data_high, data_low};
    end
  end

  // Erase and program timer
  wire timer_done;
  wire setup_end = state == ST_SETUP & o_cycle_en
    & setup_cnt == WR_SETUP - 2'h1;
  wire go_erase = setup_end & last_word & ~seg_locked
    & ~i_powerup_timer_run;
  wire go_prog = state == ST_ERASE & timer_done;
  wire next_word = state == ST_PROG & timer_done & word_idx != BLOCK_LAST;
  wire timer_load = go_erase | go_prog | next_word;
  wire [TIMER_W-1:0] timer_count = go_erase ? TIMER_W'(P_ERASE_CYCLES)
    : TIMER_W'(P_PROG_CYCLES);

  flm_timer u_timer (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_load(timer_load),
    .i_count(timer_count),
    .o_done(timer_done)
  );

  // Write sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (set_wr) begin
          next_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // Two cycles let the two following no-operations run
        if (setup_end) begin
          next_state = go_erase ? ST_ERASE : ST_DONE;
        end
      end
      ST_ERASE: begin
        if (timer_done) begin
          next_state = ST_PROG;
        end
      end
      ST_PROG: begin
        if (timer_done & word_idx == BLOCK_LAST) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Setup and word counters
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      setup_cnt <= 2'h0;
      word_idx <= 2'h0;
    end else begin
      if (set_wr) begin
        setup_cnt <= 2'h0;
      end else if (state == ST_SETUP & o_cycle_en) begin
        setup_cnt <= setup_cnt + 2'h1;
      end
      if (go_prog) begin
        word_idx <= 2'h0;
      end else if (next_word) begin
        word_idx <= word_idx + 2'h1;
      end
    end
  end

  // Halt stops fetch only; the divider keeps running
  assign o_cpu_halt = state == ST_ERASE | state == ST_PROG;

  // Flash request; the row erase uses the row address, low bits ignored
  wire [ADDR_W-1:0] prog_addr = {word_addr[ADDR_W-1:2], word_idx};

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_flash <= '0;
    end else begin
      o_flash.rd <= rd_launch;
      o_flash.erase <= next_state == ST_ERASE;
      o_flash.prog <= next_state == ST_PROG;
      if (rd_launch) begin
        o_flash.addr <= word_addr;
      end else if (next_state == ST_ERASE) begin
        o_flash.addr <= {word_addr[ADDR_W-1:4], 4'h0};
      end else if (next_state == ST_PROG) begin
        o_flash.addr <= go_prog ? {word_addr[ADDR_W-1:2], 2'h0}
          : (next_word ? prog_addr + ADDR_W'(1) : prog_addr);
      end
      if (go_prog) begin
        o_flash.wdata <= wbuf[0];
      end else if (next_word) begin
        o_flash.wdata <= wbuf[word_idx + 2'h1];
      end
    end
  end

  // Read mux; unmapped and the unlock port read zero
  always_comb begin
    o_rdata = 8'h00;
    if (i_bus.rd) begin
      if (hit_ctl) begin
        o_rdata = {CTL_FIXED_HIGH, permit, wr_bit, rd_bit};
      end else if (hit_alow) begin
        o_rdata = addr_low;
      end else if (hit_ahigh) begin
        o_rdata = {5'h00, addr_high};
      end else if (hit_dlow) begin
        o_rdata = data_low;
      end else if (hit_dhigh) begin
        o_rdata = {2'h0, data_high};
      end
    end
  end

endmodule

//--- verilog/flm_pkg.sv
// Summary of operation
// - Read and write start bits are set-only; hardware clears them on completion.
// - Writes proceed only while write_permit is one; it clears at power-up.
// - pm_unlock_port stores nothing, reads zero, serves only the unlock sequence.
// - pm_control bit 7 reads one, bits 6..3 read zero, writes ignored.
// - Word address is pm_addr_high[2:0] over pm_addr_low; upper bits read zero.
// - Word is 14 bits: pm_data_high[5:0] over pm_data_low; bits 7..6 read zero.
// - Next instruction runs; second cycle after read start is discarded for read.
// - Flash read takes one cycle; data lands next cycle, then read bit clears.
// - Data registers hold last read until another read or software write.
// - Words in write-protected segments must never be altered.
// - Writes use aligned four-word blocks starting at low bits 00.
// - Write start at low bits not 11 only latches the word into the buffer.
// - Write start at low bits 11 erases the sixteen-word row, then programs four.
// - Two setup cycles follow write start; software places two no-operations.
// - Processor halts about 4 ms during erase and program; clocks keep running.
// - After the long write, execution resumes at the third following instruction.
// - Writes are blocked while the 64 ms power-up timer runs.
package flm_pkg;

  // Register offsets on the special function register port
  localparam logic [7:0] ADDR_CONTROL = 8'h93;
  localparam logic [7:0] ADDR_UNLOCK = 8'h94;
  localparam logic [7:0] ADDR_ADDR_LOW = 8'h95;
  localparam logic [7:0] ADDR_ADDR_HIGH = 8'h96;
  localparam logic [7:0] ADDR_DATA_LOW = 8'h97;
  localparam logic [7:0] ADDR_DATA_HIGH = 8'h98;

  // Control register fields
  localparam int CTL_RD = 0;
  localparam int CTL_WR = 1;
  localparam int CTL_PERMIT = 2;
  localparam logic [4:0] CTL_FIXED_HIGH = 5'h10;

  // Widths
  localparam int ADDR_W = 11;
  localparam int ADDR_HIGH_W = 3;
  localparam int DATA_HIGH_W = 6;
  localparam int WORD_W = 14;
  localparam int BLOCK_WORDS = 4;

  // Unlock keys and block position
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
  localparam logic [1:0] BLOCK_LAST = 2'h3;

  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Instruction cycle and sequencing counts
  localparam logic [2:0] CYCLE_DIV = 3'h4;
  localparam logic [1:0] READ_DELAY = 2'h2;
  localparam logic [1:0] WR_SETUP = 2'h2;

  // Erase and program times, split of the typical 4 ms halt
  localparam int CLK_MHZ = 200;
  localparam int T_ERASE_US = 2000;
  localparam int T_PROG_US = 500;
  localparam int ERASE_CYCLES = T_ERASE_US * CLK_MHZ;
  localparam int PROG_CYCLES = T_PROG_US * CLK_MHZ;
  localparam int TIMER_W = 20;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_ERASE = 3'h3,
    ST_PROG = 3'h2,
    ST_DONE = 3'h6
  } flm_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } flm_bus_req_t;

  typedef struct packed {
    logic rd;
    logic erase;
    logic prog;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } flm_flash_req_t;

endpackage

//--- verilog/flm_unlock.sv
`timescale 1ns/1ps
module flm_unlock
  import flm_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Bus events
  input wire logic i_key_write,
  input wire logic i_clear,
  input wire logic [7:0] i_wdata,
  // Status
  output logic o_armed
);

  logic [1:0] step;
  logic [1:0] next_step;

  // Any write between the keys and the start breaks the pair
  always_comb begin
    next_step = step;
    if (i_key_write) begin
      if (i_wdata == UNLOCK_KEY1) begin
        next_step = 2'h1;
      end else if (i_wdata == UNLOCK_KEY2 && step == 2'h1) begin
        next_step = 2'h2;
      end else begin
        next_step = 2'h0;
      end
    end else if (i_clear) begin
      next_step = 2'h0;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      step <= 2'h0;
    end else begin
      step <= next_step;
    end
  end

  assign o_armed = (step == 2'h2);

endmodule

//--- verilog/flm_timer.sv
`timescale 1ns/1ps
module flm_timer
  import flm_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Control
  input wire logic i_load,
  input wire logic [TIMER_W-1:0] i_count,
  // Expiry pulse
  output logic o_done
);

  logic [TIMER_W-1:0] count;
  logic running;

  // Counts down a loaded interval, one pulse at the end
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      count <= '0;
      running <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= running && count == TIMER_W'(1);
      if (i_load) begin
        count <= i_count;
        running <= 1'b1;
      end else if (running) begin
        count <= count - TIMER_W'(1);
        running <= count != TIMER_W'(1);
      end
    end
  end

endmodule

//--- bench/flm_ctrl_asserts.sv
`timescale 1ns/1ps
module flm_ctrl_asserts
  import flm_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Watched ports
  input wire flm_bus_req_t i_bus,
  input wire logic [7:0] o_rdata,
  input wire flm_flash_req_t o_flash,
  input wire logic o_cycle_en,
  input wire logic o_fetch_discard,
  input wire logic o_cpu_halt,
  input wire logic [3:0] i_seg_protected
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  // Register read decodes
  wire rd_unl = i_bus.rd && i_bus.addr == ADDR_UNLOCK;
  wire rd_ctl = i_bus.rd && i_bus.addr == ADDR_CONTROL;
  wire rd_adh = i_bus.rd && i_bus.addr == ADDR_ADDR_HIGH;
  wire rd_dth = i_bus.rd && i_bus.addr == ADDR_DATA_HIGH;

  chk_cycle_period: assert property (o_cycle_en |=>
    !o_cycle_en [*3] ##1 o_cycle_en) else $error("cycle enable spacing");
  chk_unlock_zero: assert property (rd_unl |-> o_rdata == 8'h00)
    else $error("unlock port not zero");
  chk_ctl_fixed: assert property (rd_ctl |->
    o_rdata[7:3] == CTL_FIXED_HIGH) else $error("control fixed bits");
  chk_addr_high_pad: assert property (rd_adh |->
    o_rdata[7:3] == 5'h00) else $error("address high pad bits");
  chk_data_high_pad: assert property (rd_dth |->
    o_rdata[7:6] == 2'h0) else $error("data high pad bits");
  chk_read_discard: assert property (o_flash.rd |->
    o_fetch_discard ##1 !o_flash.rd) else $error("flash read timing");
  chk_erase_guard: assert property (o_flash.erase |->
    !i_seg_protected[o_flash.addr[10:9]]) else $error("protected erase");
  chk_erase_row: assert property (o_flash.erase |->
    o_cpu_halt && o_flash.addr[3:0] == 4'h0) else $error("erase row");
  chk_erase_hold: assert property ($rose(o_flash.erase) |->
    o_flash.erase [*8]) else $error("erase too short");
  chk_prog_follow: assert property ($fell(o_flash.erase) |->
    ##[0:2] (o_flash.prog && o_flash.addr[1:0] == 2'h0))
    else $error("program not after erase");
endmodule

bind flm_ctrl flm_ctrl_asserts flm_ctrl_asserts_i (.i_clk_sys, .i_reset,
  .i_bus, .o_rdata, .o_flash, .o_cycle_en, .o_fetch_discard, .o_cpu_halt,
  .i_seg_protected);

//--- bench/flm_flash_model.sv
`timescale 1ns/1ps
module flm_flash_model
  import flm_pkg::*;
#(
  parameter logic [WORD_W-1:0] P_ERASED = 14'h3FFF
) (
  // Clock
  input wire logic i_clk_sys,
  // Array request and data
  input wire flm_flash_req_t i_flash,
  output logic [WORD_W-1:0] o_rdata = 14'h0000
);
  logic [WORD_W-1:0] mem [2**ADDR_W];

  // Data valid one clock after read; toggles otherwise so stale use shows
  always @(posedge i_clk_sys) begin
    if (i_flash.rd) o_rdata <= mem[i_flash.addr];
    else o_rdata <= ~o_rdata;
    if (i_flash.erase) begin
      for (int k = 0; k < 16; k++) mem[i_flash.addr | 11'(k)] <= P_ERASED;
    end
    if (i_flash.prog) mem[i_flash.addr] <= i_flash.wdata;
  end
endmodule

//--- bench/test_flash_self_rw_controller.sv
`timescale 1ns/1ps
module test_flash_self_rw_controller;
  import flm_pkg::*;
  localparam logic [13:0] ERASED = 14'h3FFF;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  flm_bus_req_t bus = '0;
  logic [7:0] rdata, v;
  flm_flash_req_t flash;
  logic [13:0] frd, w, blk [4];
  logic cyc, disc, halt, pu = 1'b0;
  logic [3:0] prot = 4'h0;
  logic [10:0] a, base;
  logic [31:0] seed = 32'h5A555A35;
  int n_fail = 0, num_checks = 0, halts = 0, h;
  int ref_mem [2048];

  always #2.5 i_clk_sys = ~i_clk_sys;
  // Stall cycles seen, to tell buffered words from the long write
  always @(posedge i_clk_sys) if (halt === 1'b1) halts++;

  flm_ctrl #(.P_ERASE_CYCLES(20), .P_PROG_CYCLES(5)) flm_ctrl_i (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_bus(bus),
    .o_rdata(rdata), .o_flash(flash), .i_flash_rdata(frd),
    .o_cycle_en(cyc), .o_fetch_discard(disc), .o_cpu_halt(halt),
    .i_seg_protected(prot), .i_powerup_timer_run(pu));
  flm_flash_model flm_flash_model_i (.i_clk_sys(i_clk_sys),
    .i_flash(flash), .o_rdata(frd));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One bus access over two clocks; read data taken while rd is high
  task automatic op(input logic wr, input logic [7:0] ad, d);
    @(negedge i_clk_sys) bus = {wr, ~wr, ad, d};
    #1 v = rdata;
    @(negedge i_clk_sys) bus = '0;
  endtask

  task automatic poll(input int b);
    int i;
    for (i = 0; i < 400; i++) begin
      op(1'b0, ADDR_CONTROL, 8'h00);
      if (v[b] === 1'b0) break;
    end
    if (i == 400) chk("start_bit_clear", 16'h0000, 16'h0001);
  endtask

  task automatic set_addr(input logic [10:0] ad);
    op(1'b1, ADDR_ADDR_LOW, ad[7:0]);
    op(1'b1, ADDR_ADDR_HIGH, {5'h00, ad[10:8]});
  endtask

  task automatic read_word(input logic [10:0] ad);
    set_addr(ad);
    op(1'b1, ADDR_CONTROL, 8'h01);
    op(1'b1, ADDR_CONTROL, 8'h00);
    op(1'b0, ADDR_CONTROL, 8'h00);
    chk("read_bit_held", 16'h0001, {15'h0000, v[0]});
    poll(0);
    op(1'b0, ADDR_DATA_LOW, 8'h00);
    w[7:0] = v;
    op(1'b0, ADDR_DATA_HIGH, 8'h00);
    w[13:8] = v[5:0];
    chk("read_word", 16'(ref_mem[ad]), {2'h0, w});
  endtask

  // Full write of one word: load, permit, unlock pair, start
  task automatic write_word(input logic [10:0] ad, input logic [13:0] d);
    set_addr(ad);
    op(1'b1, ADDR_DATA_LOW, d[7:0]);
    op(1'b1, ADDR_DATA_HIGH, {2'h0, d[13:8]});
    op(1'b1, ADDR_CONTROL, 8'h04);
    op(1'b1, ADDR_UNLOCK, UNLOCK_KEY1);
    op(1'b1, ADDR_UNLOCK, UNLOCK_KEY2);
    op(1'b1, ADDR_CONTROL, 8'h06);
    poll(1);
  endtask

  initial begin
    for (int k = 0; k < 2048; k++) begin
      seed = lfsr(seed);
      ref_mem[k] = seed[13:0];
      flm_flash_model_i.mem[k] = seed[13:0];
    end
    repeat (5) @(posedge i_clk_sys);
    @(negedge i_clk_sys) i_reset = 1'b0;
    // Reset values of every register
    for (int k = 0; k < 6; k++) begin
      op(1'b0, ADDR_CONTROL + 8'(k), 8'h00);
      chk("reset_value", (k == 0) ? 16'h0080 : 16'h0000, v);
    end
    // Unimplemented bits ignore writes
    op(1'b1, ADDR_CONTROL, 8'hF8);
    op(1'b1, ADDR_UNLOCK, 8'hFF);
    op(1'b1, ADDR_ADDR_HIGH, 8'hFF);
    op(1'b1, ADDR_DATA_HIGH, 8'hFF);
    op(1'b0, ADDR_CONTROL, 8'h00);
    chk("control_fixed", 16'h0080, v);
    op(1'b0, ADDR_UNLOCK, 8'h00);
    chk("unlock_read", 16'h0000, v);
    op(1'b0, ADDR_ADDR_HIGH, 8'h00);
    chk("addr_high", 16'h0007, v);
    op(1'b0, ADDR_DATA_HIGH, 8'h00);
    chk("data_high", 16'h003F, v);
    repeat (4) begin
      seed = lfsr(seed);
      read_word(seed[10:0]);
    end
    // Refused starts: no unlock, then unlock without permit
    h = halts;
    set_addr(11'h013);
    op(1'b1, ADDR_CONTROL, 8'h04);
    op(1'b1, ADDR_CONTROL, 8'h06);
    op(1'b0, ADDR_CONTROL, 8'h00);
    chk("start_no_unlock", 16'h0084, v);
    op(1'b1, ADDR_CONTROL, 8'h00);
    op(1'b1, ADDR_UNLOCK, UNLOCK_KEY1);
    op(1'b1, ADDR_UNLOCK, UNLOCK_KEY2);
    op(1'b1, ADDR_CONTROL, 8'h02);
    op(1'b0, ADDR_CONTROL, 8'h00);
    chk("start_no_permit", 16'h0080, v);
    op(1'b0, ADDR_DATA_LOW, 8'h00);
    chk("data_held", {8'h00, w[7:0]}, v);
    chk("no_halt", 16'(h), 16'(halts));
    // Block writes: open, protected segment, power-up timer running
    for (int c = 0; c < 3; c++) begin
      seed = lfsr(seed);
      base = {seed[10:2], 2'h0};
      prot = (c == 1) ? 4'h1 << base[10:9] : 4'h0;
      pu = (c == 2);
      for (int i = 0; i < 4; i++) begin
        seed = lfsr(seed);
        blk[i] = seed[13:0];
        // One kept word: read it back and rewrite the same value
        if (c == 0 && i == 1) begin
          read_word(base + 11'(i));
          blk[i] = w;
        end
        h = halts;
        write_word(base + 11'(i), blk[i]);
        if (i < 3) chk("buffer_only", 16'(h), 16'(halts));
      end
      chk("long_write", (c == 0) ? 16'h0001 : 16'h0000, 16'(halts > h));
      if (c == 0) begin
        // Other 12 row words are left erased, not restored
        for (int k = 0; k < 16; k++) ref_mem[{base[10:4], 4'(k)}] = ERASED;
        for (int i = 0; i < 4; i++) ref_mem[base + 11'(i)] = blk[i];
      end
      prot = 4'h0;
      pu = 1'b0;
      for (int k = 0; k < 16; k++) read_word({base[10:4], 4'(k)});
    end
    close_out();
  end

  // Hang guard, well past the expected run length
  initial begin
    #200000;
    n_fail++;
    close_out();
  end
endmodule
